// ===== dv/smw_channel_model.sv
// Read channel model making the 2F period strobe
module smw_channel_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Strobe
    output logic clk2f_en = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // One 2F period spans two system clocks, quiet in reset
    always @(negedge clk) begin
        clk2f_en <= !reset && !clk2f_en;
    end
endmodule

// ===== dv/smw_chk.sv
// Checker of resync sizing, miss count, ID skip and format start window
module smw_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register writes
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // Events
    input wire logic sector_1k,
    input wire logic rsync_expect,
    input wire logic data_field_start,
    input wire logic sector_start,
    // Outputs
    input wire logic rsync_window,
    input wire logic [5:0] rsync_width,
    input wire logic [1:0] miss_count,
    input wire logic id_detect_enable,
    input wire logic format_start_window_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ctrl_r;
    logic [3:0] len_r;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Shadow copies of the programmed fields
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= 8'h00;
            len_r <= 4'h8;
        end else if (reg_wr && reg_addr == 8'h28) begin
            ctrl_r <= reg_wdata;
        end else if (reg_wr && reg_addr == 8'h29) begin
            len_r <= reg_wdata[3:0];
        end
    end
    win_open_a: assert property (rsync_expect |=> rsync_window)
        else $error("window not opened");
    fix_narrow_a: assert property (rsync_expect && ctrl_r[3:2] == 2'h2 |=> rsync_width == 6'h13)
        else $error("narrow width wrong");
    fix_wide_a: assert property (rsync_expect && ctrl_r[3:2] == 2'h3 |=> rsync_width == 6'h23)
        else $error("wide width wrong");
    small_first_a: assert property (rsync_expect && ctrl_r[3:2] == 2'h0 && !sector_1k
        && miss_count == 2'h0 |=> rsync_width == 6'h09) else $error("small width wrong");
    large_top_a: assert property (rsync_expect && ctrl_r[3:2] == 2'h1 && sector_1k
        && miss_count == 2'h3 |=> rsync_width == 6'h39) else $error("large width wrong");
    miss_step_a: assert property (miss_count != $past(miss_count) && miss_count != 2'h0
        |-> miss_count == $past(miss_count) + 2'h1) else $error("miss step wrong");
    miss_clear_a: assert property (data_field_start |=> miss_count == 2'h0)
        else $error("miss not cleared");
    skip_hold_a: assert property (sector_start && ctrl_r[1:0] != 2'h0 |=> !id_detect_enable)
        else $error("ID detect not held off");
    skip_none_a: assert property (sector_start && ctrl_r[1:0] == 2'h0 |=> id_detect_enable)
        else $error("ID detect not enabled");
    zero_len_a: assert property (len_r == 4'h0 |-> !format_start_window_out)
        else $error("window with zero length");
endmodule

// ===== dv/smw_sync_mark_window_control_test.sv
// Bench for the sync mark window block
module smw_sync_mark_window_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sector_1k = 1'b0;
    logic rsync_expect = 1'b0;
    logic rsync_found = 1'b0;
    logic data_field_start = 1'b0;
    logic sector_start = 1'b0;
    logic id_field_end = 1'b0;
    logic true_sector_mark = 1'b0;
    logic offset_flag_ref = 1'b0;
    logic clk2f_en;
    logic [7:0] reg_rdata;
    logic rsync_window;
    logic [5:0] rsync_width;
    logic [1:0] miss_count;
    logic id_detect_enable;
    logic format_start_window_out;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    localparam logic [5:0] WTAB [16] = '{6'h09, 6'h0f, 6'h13, 6'h19, 6'h0b, 6'h11, 6'h19,
        6'h1f, 6'h0f, 6'h19, 6'h23, 6'h2d, 6'h11, 6'h1f, 6'h2d, 6'h39};
    smw_sync_mark_window_control i_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .clk2f_en, .sector_1k, .rsync_expect, .rsync_found,
        .data_field_start, .sector_start, .id_field_end, .true_sector_mark, .offset_flag_ref,
        .rsync_window, .rsync_width, .miss_count, .id_detect_enable, .format_start_window_out);
    smw_channel_model i_chan (.clk, .reset, .clk2f_en);
    always #20 clk = !clk;
    // Cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        pulse(reg_wr);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        pulse(reg_rd);
        chk(reg_rdata, exp);
    endtask
    task automatic waitlow;
        for (int i = 0; i < 200 && rsync_window === 1'b1; i++) tick(1);
        tick(2);
    endtask
    task automatic t_regs;
        rdc(8'h28, 8'h00);
        rdc(8'h29, 8'h88);
        wr(8'h28, 8'h0f);
        rdc(8'h28, 8'h0f);
        rdc(8'h2a, 8'h00);
    endtask
    task automatic t_rsync;
        logic [5:0] w;
        for (int md = 0; md < 4; md++) begin
            for (int s = 0; s < 2; s++) begin
                wr(8'h28, 8'(md << 2));
                sector_1k = s[0];
                pulse(data_field_start);
                chk({6'h0, miss_count}, 8'h00);
                for (int m = 0; m < 5; m++) begin
                    w = md > 1 ? (md == 2 ? 6'h13 : 6'h23) : WTAB[md * 8 + s * 4 + (m > 3 ? 3 : m)];
                    pulse(rsync_expect);
                    chk({2'h0, rsync_width}, {2'h0, w});
                    waitlow();
                    chk({6'h0, miss_count}, m > 2 ? 8'h03 : 8'(m + 1));
                end
                pulse(rsync_expect);
                pulse(rsync_found);
                waitlow();
                chk({6'h0, miss_count}, 8'h00);
            end
        end
    endtask
    task automatic t_skip;
        for (int k = 0; k < 4; k++) begin
            wr(8'h28, 8'(k));
            pulse(sector_start);
            chk({7'h0, id_detect_enable}, 8'(k == 0));
            for (int f = 1; f < 4; f++) begin
                pulse(id_field_end);
                chk({7'h0, id_detect_enable}, 8'(k == 0 || (k < 3 && f >= k)));
            end
        end
    endtask
    task automatic t_fmt(input logic [7:0] tim);
        int n;
        int hi;
        int en_hi;
        logic was_hi;
        n = 0;
        hi = 0;
        en_hi = 0;
        was_hi = 1'b0;
        wr(8'h29, tim);
        pulse(true_sector_mark);
        pulse(offset_flag_ref);
        // Length counted in 2F strobes taken while open, free of strobe phase
        for (int i = 0; i < 400; i++) begin
            en_hi += int'(was_hi && clk2f_en === 1'b1);
            was_hi = format_start_window_out === 1'b1;
            hi += int'(was_hi);
            n += int'(hi == 0);
            tick(1);
        end
        chk(8'(en_hi), 8'(tim[3:0] * 2));
        if (tim[3:0] != 4'h0) begin
            chk(8'(n + 2 >= tim[7:4] * 4 && n <= tim[7:4] * 4 + 3), 8'h01);
        end
    endtask
    initial begin
        tick(10);
        reset = 1'b0;
        t_regs();
        t_rsync();
        t_skip();
        t_fmt(8'h88);
        t_fmt(8'h21);
        t_fmt(8'h0f);
        t_fmt(8'h30);
        results();
    end
endmodule
bind smw_sync_mark_window_control smw_chk i_chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .sector_1k, .rsync_expect, .data_field_start, .sector_start, .rsync_window, .rsync_width,
    .miss_count, .id_detect_enable, .format_start_window_out);

// ===== rtl/smw_pkg.sv
// Package of offsets, field layouts and constants for the sync mark window block
package smw_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SMW_WIN_CTRL_OFS = 8'h28;
    localparam logic [7:0] SMW_FMT_TIMING_OFS = 8'h29;
    localparam logic [7:0] SMW_WIN_CTRL_RST = 8'h00;
    localparam logic [7:0] SMW_FMT_TIMING_RST = 8'h88;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SMW_RSYNC_MODE_LSB = 2;
    localparam int SMW_ID_SKIP_LSB = 0;
    localparam int SMW_FMT_DELAY_LSB = 4;
    localparam int SMW_FMT_LEN_LSB = 0;

    // ------------------------------------------------------------
    // Resync window modes
    // ------------------------------------------------------------
    localparam logic [1:0] SMW_MODE_SMALL = 2'h0;
    localparam logic [1:0] SMW_MODE_LARGE = 2'h1;
    localparam logic [1:0] SMW_MODE_FIX_NARROW = 2'h2;
    localparam logic [1:0] SMW_MODE_FIX_WIDE = 2'h3;

    // ------------------------------------------------------------
    // Window widths in 2F periods
    // ------------------------------------------------------------
    localparam logic [5:0] SMW_W_SM512 [4] = '{6'h09, 6'h0f, 6'h13, 6'h19};
    localparam logic [5:0] SMW_W_SM1K [4] = '{6'h0b, 6'h11, 6'h19, 6'h1f};
    localparam logic [5:0] SMW_W_LG512 [4] = '{6'h0f, 6'h19, 6'h23, 6'h2d};
    localparam logic [5:0] SMW_W_LG1K [4] = '{6'h11, 6'h1f, 6'h2d, 6'h39};
    localparam logic [5:0] SMW_W_FIX_NARROW = 6'h13;
    localparam logic [5:0] SMW_W_FIX_WIDE = 6'h23;

    // ------------------------------------------------------------
    // Counting units
    // ------------------------------------------------------------
    localparam logic [1:0] SMW_MISS_MAX = 2'h3;
    localparam int SMW_2F_PER_UNIT = 2;

endpackage

// ===== rtl/smw_sync_mark_window_control.sv
// Resync window sizing, ID skip and format start window timing
// Function
// - Two-bit field picks four resync behaviours
// - Widths in 2F periods, per sector size in small and large modes
// - Small progressive widths by missed count
// - Large progressive widths by missed count
// - Fixed narrow window of 19 periods
// - Fixed wide window of 35 periods
// - Count missed marks, saturate at three
// - Hold off ID detection for skipped fields
// - Skip codes zero to two fields; code three holds ID detection off for the whole sector
// - Format start window after programmed delay
// - Format start window length from nibble
// - Zero length at the true sector mark never arms the window
// - Two 2F periods equal one bit
module smw_sync_mark_window_control
    import smw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Timing from parent datapath
    input wire logic clk2f_en,
    input wire logic sector_1k,
    // Resync mark events
    input wire logic rsync_expect,
    input wire logic rsync_found,
    input wire logic data_field_start,
    // ID field events
    input wire logic sector_start,
    input wire logic id_field_end,
    // Sector mark events
    input wire logic true_sector_mark,
    input wire logic offset_flag_ref,
    // Outputs
    output logic rsync_window,
    output logic [5:0] rsync_width,
    output logic [1:0] miss_count,
    output logic id_detect_enable,
    output logic format_start_window_out
);

    typedef enum logic [1:0] {
        SMW_FS_IDLE,
        SMW_FS_ARMED,
        SMW_FS_DELAY,
        SMW_FS_OPEN
    } smw_fs_state_type;

    logic [7:0] win_ctrl_r;
    logic [7:0] fmt_timing_r;
    logic [1:0] miss_r;
    logic [5:0] width_nxt;
    logic [1:0] id_seen_r;
    logic id_en_r;
    logic fs_out_r;
    logic [5:0] width_r;
    smw_fs_state_type fs_state_r;
    logic win_open;
    logic win_expired;
    logic tmr_load;
    logic [3:0] tmr_units;
    logic tmr_done;
    logic [1:0] mode;
    logic [1:0] id_skip;
    logic [3:0] fmt_delay;
    logic [3:0] fmt_len;
    logic hit_r;

    assign mode = win_ctrl_r[SMW_RSYNC_MODE_LSB +: 2];
    assign id_skip = win_ctrl_r[SMW_ID_SKIP_LSB +: 2];
    assign fmt_delay = fmt_timing_r[SMW_FMT_DELAY_LSB +: 4];
    assign fmt_len = fmt_timing_r[SMW_FMT_LEN_LSB +: 4];

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Register writes
    always_ff @(posedge clk) begin
        if (reset) begin
            win_ctrl_r <= SMW_WIN_CTRL_RST;
            fmt_timing_r <= SMW_FMT_TIMING_RST;
        end else if (reg_wr) begin
            if (reg_addr == SMW_WIN_CTRL_OFS) begin
                win_ctrl_r <= reg_wdata;
            end
            if (reg_addr == SMW_FMT_TIMING_OFS) begin
                fmt_timing_r <= reg_wdata;
            end
        end
    end

    // Read data, zero on unmapped address
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                SMW_WIN_CTRL_OFS: reg_rdata <= win_ctrl_r;
                SMW_FMT_TIMING_OFS: reg_rdata <= fmt_timing_r;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Resync window sizing
    // ------------------------------------------------------------
    // mode width select
    always_comb begin
        width_nxt = SMW_W_FIX_NARROW;
        case (mode)
            SMW_MODE_SMALL: begin
                width_nxt = sector_1k ? SMW_W_SM1K[miss_r] : SMW_W_SM512[miss_r];
            end
            SMW_MODE_LARGE: begin
                width_nxt = sector_1k ? SMW_W_LG1K[miss_r] : SMW_W_LG512[miss_r];
            end
            SMW_MODE_FIX_NARROW: width_nxt = SMW_W_FIX_NARROW;
            SMW_MODE_FIX_WIDE: width_nxt = SMW_W_FIX_WIDE;
            default: width_nxt = SMW_W_FIX_NARROW;
        endcase
    end

    // Width latched when a window opens, so it stays steady inside it
    always_ff @(posedge clk) begin
        if (reset) begin
            width_r <= SMW_W_SM512[0];
        end else if (rsync_expect) begin
            width_r <= width_nxt;
        end
    end

    smw_window_timer u_win (
        .clk(clk),
        .reset(reset),
        .clk2f_en(clk2f_en),
        .start(rsync_expect),
        .width(width_nxt),
        .open_w(win_open),
        .expired(win_expired)
    );

    // Mark seen in the current window; without it a hit window would
    // still run out and be counted as a miss at its end.
    // A new window starts with a clean slate: a late hit belongs to the old one.
    // hit cancels the miss
    always_ff @(posedge clk) begin
        if (reset) begin
            hit_r <= 1'b0;
        end else if (rsync_expect) begin
            hit_r <= 1'b0;
        end else if (rsync_found && win_open) begin
            hit_r <= 1'b1;
        end
    end

    // Missed mark count; a hit or data field start wins over a miss
    always_ff @(posedge clk) begin
        if (reset) begin
            miss_r <= 2'h0;
        end else if (data_field_start || (rsync_found && win_open)) begin
            miss_r <= 2'h0;
        end else if (win_expired && !hit_r && miss_r != SMW_MISS_MAX) begin
            miss_r <= miss_r + 2'h1;
        end
    end

    assign rsync_window = win_open;
    assign rsync_width = width_r;
    assign miss_count = miss_r;

    // ------------------------------------------------------------
    // ID field skip
    // ------------------------------------------------------------
    // hold off ID
    always_ff @(posedge clk) begin
        if (reset) begin
            id_seen_r <= 2'h0;
            id_en_r <= 1'b0;
        end else if (sector_start) begin
            id_seen_r <= 2'h0;
            id_en_r <= (id_skip == 2'h0);
        end else if (id_field_end && !id_en_r && id_seen_r != 2'h3) begin
            id_seen_r <= id_seen_r + 2'h1;
            id_en_r <= ((id_seen_r + 2'h1) == id_skip) && (id_skip != 2'h3);
        end
    end

    assign id_detect_enable = id_en_r;

    // ------------------------------------------------------------
    // Format start window
    // ------------------------------------------------------------
    // Sequence: armed by true mark, delay from reference, then open
    always_ff @(posedge clk) begin
        if (reset) begin
            fs_state_r <= SMW_FS_IDLE;
            fs_out_r <= 1'b0;
        end else begin
            case (fs_state_r)
                SMW_FS_IDLE: begin
                    fs_out_r <= 1'b0;
                    if (true_sector_mark && fmt_len != 4'h0) begin
                        fs_state_r <= SMW_FS_ARMED;
                    end
                end
                SMW_FS_ARMED: begin
                    if (offset_flag_ref) begin
                        fs_state_r <= SMW_FS_DELAY;
                    end
                end
                SMW_FS_DELAY: begin
                    if (tmr_done) begin
                        fs_state_r <= SMW_FS_OPEN;
                        fs_out_r <= 1'b1;
                    end
                end
                SMW_FS_OPEN: begin
                    if (tmr_done) begin
                        fs_state_r <= SMW_FS_IDLE;
                        fs_out_r <= 1'b0;
                    end
                end
                default: begin
                    fs_state_r <= SMW_FS_IDLE;
                    fs_out_r <= 1'b0;
                end
            endcase
        end
    end

    // Timer load on entry to delay and to open phases
    assign tmr_load = (fs_state_r == SMW_FS_ARMED && offset_flag_ref)
        || (fs_state_r == SMW_FS_DELAY && tmr_done);
    assign tmr_units = (fs_state_r == SMW_FS_ARMED) ? fmt_delay : fmt_len;

    smw_unit_timer u_fs_tmr (
        .clk(clk),
        .reset(reset),
        .clk2f_en(clk2f_en),
        .load(tmr_load),
        .units(tmr_units),
        .busy(),
        .done(tmr_done)
    );

    assign format_start_window_out = fs_out_r;

endmodule

// ===== rtl/smw_unit_timer.sv
// Down counter of units of two 2F periods
module smw_unit_timer
    import smw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic clk2f_en,
    input wire logic load,
    input wire logic [3:0] units,
    // Status
    output logic busy,
    output logic done
);

    logic [4:0] cnt_r;
    logic half_r;

    // ------------------------------------------------------------
    // Count
    // ------------------------------------------------------------
    // two 2F per bit
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (reset) begin
            cnt_r <= 5'h00;
            half_r <= 1'b0;
        end else if (load) begin
            cnt_r <= {1'b0, units};
            half_r <= 1'b0;
            done <= (units == 4'h0);
        end else if (clk2f_en && cnt_r != 5'h00) begin
            half_r <= ~half_r;
            if (half_r) begin
                cnt_r <= cnt_r - 5'h01;
                done <= (cnt_r == 5'h01);
            end
        end
    end

    assign busy = (cnt_r != 5'h00);

endmodule

// ===== rtl/smw_window_timer.sv
// Resync window width counter in 2F periods
module smw_window_timer
    import smw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic clk2f_en,
    input wire logic start,
    input wire logic [5:0] width,
    // Status
    output logic open_w,
    output logic expired
);

    logic [5:0] cnt_r;

    // ------------------------------------------------------------
    // Width count
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        expired <= 1'b0;
        if (reset) begin
            cnt_r <= 6'h00;
        end else if (start) begin
            cnt_r <= width;
        end else if (clk2f_en && cnt_r != 6'h00) begin
            cnt_r <= cnt_r - 6'h01;
            expired <= (cnt_r == 6'h01);
        end
    end

    assign open_w = (cnt_r != 6'h00);

endmodule
